// >>> verilog/uog_top.sv
// General and on-the-go control of a dual-role USB controller: bus power
// and cable id qualification, role choice, controller enable and clock
// freeze, power-switch pin, session and negotiation requests, OTG timers.
// Assumes pad comparators and the id pin are asynchronous, controller
// events are one-cycle pulses on ref_clk, and an APB master.
//
// How it works
// - Host role: set at high threshold, clear below session
// - Peripheral role: bus-power flag follows session valid
// - Any bus-power flag change sets its flag
// - Id changes (A plug) set id flag
// - Pin source, no plug: id high, peripheral
// - Role bit 7 selects device, ignored under pin
// - Switch-pin enable and pad regulator enable outputs
// - Controller enable clear resets, gates clocks, transceiver
// - Clock freeze resets set, stops clocks, resume stays
// - Pad enable works with controller disabled
// - Speed bit shows full speed, host only
// - Status shows id level and bus power
// - Transition flags set by hardware, enabled for interrupt
// - Direct-access bit routes data port to RAM
// - Eleven-bit RAM address from high, low registers
// - Negotiation request starts or accepts by role
// - Session request self-clears when started
// - Session method select; hardware power control disable
// - Power request drives pin; clear bit self-clears
// - Timer register page, value, top bit one
// - Suspend timeout flag; six OTG enables gate
// - Page selects which of four timers
// - Frozen clock blocks all but transition events
// - Role swap, connection, drop, session flags
`default_nettype none
module uog_top #(
    parameter int unsigned SUSPEND_TIMEOUT_CYCLES = uog_pkg::SUSPEND_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads, asynchronous
    input wire logic id_pin,
    input wire logic session_valid,
    input wire logic high_threshold_valid,
    output logic power_switch_pin,
    output logic pad_regulator_en,
    output logic otg_pad_enable,
    // Controller control
    output logic ctrl_reset,
    output logic ctrl_clk_en,
    output logic transceiver_en,
    output logic resume_detect_en,
    output logic host_role,
    output logic host_select,
    input wire logic full_speed,
    // Suspend level, then controller events as one-cycle pulses
    input wire logic suspend_active,
    input wire logic negotiation_error_evt,
    input wire logic role_swap_evt,
    input wire logic bconn_error_evt,
    input wire logic power_drop_evt,
    input wire logic session_detect_evt,
    // Protocol requests
    output logic negotiation_request,
    output logic session_request_start,
    output logic session_method_select,
    // RAM direct access
    input wire logic endpoint_data_access,
    output logic ram_direct_access,
    output logic [10:0] ram_direct_addr,
    // Timer settings, one per page
    output logic [2:0] vrise_timeout_sel,
    output logic [2:0] bus_pulse_sel,
    output logic [2:0] pulldown_timeout_sel,
    output logic [2:0] session_detect_sel,
    // Interrupt request
    output logic usb_gen_irq
);
    import uog_pkg::*;

    if (SUSPEND_TIMEOUT_CYCLES < 2) begin : g_bad_timeout
        $error("SUSPEND_TIMEOUT_CYCLES must be at least 2");
    end

    logic [7:0] hw_config; // Role source, switch pin, regulator
    logic [7:0] gen_control; // Enable, freeze, pad, int enables
    logic [7:0] gen_flags; // Id and bus-power transition flags
    logic [7:0] otg_control; // Requests and method bits
    logic [7:0] otg_enable; // OTG interrupt enables
    logic [7:0] otg_flags; // OTG event flags
    logic [1:0] timer_page; // Selected timer page
    logic [2:0] timer_value [4]; // One setting per page
    logic [2:0] sync1; // First stage, read by sync2 only
    logic [2:0] sync2; // Stable id, session, high threshold
    logic id_prev; // Id level one cycle ago
    logic bus_power; // Qualified bus-power flag
    logic bus_power_prev; // For transition detection
    logic [31:0] susp_cnt; // Suspend duration counter
    logic sto_evt; // Suspend timeout pulse
    logic wr_en; // APB write in access phase
    logic rd_setup; // APB setup phase
    logic mapped; // Address hits a register
    logic [7:0] next_rdata; // Read mux
    logic [7:0] wbyte; // Low write byte
    logic [7:0] otg_set; // Hardware set requests
    logic [7:0] gen_set; // Hardware set requests

    logic controller_enable;
    logic clock_freeze;
    logic id_s;
    logic sv_s;
    logic hi_s;
    logic power_request;
    logic session_request;

    assign controller_enable = gen_control[CTRL_EN_BIT];
    assign clock_freeze = gen_control[FREEZE_BIT];
    assign id_s = sync2[2];
    assign sv_s = sync2[1];
    assign hi_s = sync2[0];
    assign power_request = otg_control[PWR_REQ_BIT];
    assign session_request = otg_control[SES_REQ_BIT];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    // Pad inputs pass two flops before any logic looks at them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
        end else begin
            sync1 <= {id_pin, session_valid, high_threshold_valid};
            sync2 <= sync1;
        end
    end

    // pin source idles high; register bit else
    always_comb begin
        if (hw_config[ROLE_PIN_BIT]) begin
            host_role = !id_s;
        end else begin
            host_role = !hw_config[ROLE_REG_BIT];
        end
    end

    // Bus-power qualification; a disabled pad reads no power
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bus_power <= 1'b0;
        end else if (!gen_control[PAD_EN_BIT]) begin
            // detection depends only on pad enable
            bus_power <= 1'b0;
        end else if (host_role) begin
            if (hi_s) begin
                bus_power <= 1'b1;
            end else if (!sv_s) begin
                bus_power <= 1'b0;
            end
        end else begin
            bus_power <= sv_s;
        end
    end

    // Previous levels for transition detection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            id_prev <= 1'b1;
            bus_power_prev <= 1'b0;
        end else begin
            id_prev <= id_s;
            bus_power_prev <= bus_power;
        end
    end

    // Suspend timer; the count clears to zero while frozen, so no timeout then
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            susp_cnt <= 32'h0;
        end else if (!suspend_active || clock_freeze) begin
            susp_cnt <= 32'h0;
        end else if (susp_cnt != 32'(SUSPEND_TIMEOUT_CYCLES)) begin
            susp_cnt <= susp_cnt + 32'h1;
        end
    end

    // fires once when suspend outlasts the limit
    assign sto_evt = suspend_active && !clock_freeze
        && (susp_cnt == 32'(SUSPEND_TIMEOUT_CYCLES - 1));

    // Hardware set terms; the set wins over a same-cycle clear
    always_comb begin
        gen_set = 8'h00;
        // both edges of the bus-power flag
        gen_set[0] = bus_power != bus_power_prev;
        // a B plug keeps id high, so only A plugs toggle it
        gen_set[1] = id_s != id_prev;
        otg_set = 8'h00;
        // OTG events need a running clock
        if (!clock_freeze) begin
            otg_set = {2'b00, sto_evt, negotiation_error_evt, role_swap_evt,
                bconn_error_evt, power_drop_evt, session_detect_evt};
        end
    end

    // Hardware configuration register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hw_config <= RST_ZERO;
        end else if (wr_en && paddr == ADDR_HW_CONFIG) begin
            hw_config <= wbyte & MASK_HW_CONFIG;
        end
    end

    // General control register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gen_control <= RST_GEN_CONTROL;
        end else if (wr_en && paddr == ADDR_GEN_CONTROL) begin
            gen_control <= wbyte & MASK_GEN_CONTROL;
        end
    end

    // transition flags; software writes zero to clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gen_flags <= RST_ZERO;
        end else if (wr_en && paddr == ADDR_GEN_FLAGS) begin
            gen_flags <= ((gen_flags & wbyte) | gen_set) & MASK_GEN_FLAGS;
        end else begin
            gen_flags <= (gen_flags | gen_set) & MASK_GEN_FLAGS;
        end
    end

    // direct access; address, steps per data access
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ram_direct_access <= 1'b0;
            ram_direct_addr <= 11'h000;
        end else if (wr_en && paddr == ADDR_DPRAM_HIGH) begin
            ram_direct_access <= wbyte[DIRECT_BIT];
            ram_direct_addr <= {wbyte[2:0], ram_direct_addr[7:0]};
        end else if (wr_en && paddr == ADDR_DPRAM_LOW) begin
            ram_direct_addr <= {ram_direct_addr[10:8], wbyte};
        end else if (ram_direct_access && endpoint_data_access) begin
            ram_direct_addr <= ram_direct_addr + 11'h001;
        end
    end

    // OTG control register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            otg_control <= RST_ZERO;
        end else if (wr_en && paddr == ADDR_OTG_CONTROL) begin
            otg_control <= wbyte & MASK_OTG_CONTROL;
            // clear bit drops the request, never stored
            if (wbyte[PWR_CLR_BIT]) begin
                otg_control[PWR_REQ_BIT] <= 1'b0;
            end
        end else begin
            // request bit clears as the request starts
            if (session_request_start) begin
                otg_control[SES_REQ_BIT] <= 1'b0;
            end
            // hardware drops power on a bus drop unless disabled
            if (power_drop_evt && !otg_control[HW_DIS_BIT]) begin
                otg_control[PWR_REQ_BIT] <= 1'b0;
            end
        end
    end

    // start only in device role with a live controller
    assign session_request_start = session_request && !host_role
        && controller_enable && !clock_freeze;

    // timer page and per-page values; page picks timer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_page <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                timer_value[i] <= 3'h0;
            end
        end else if (wr_en && paddr == ADDR_OTG_TIMER) begin
            timer_page <= wbyte[6:5];
            timer_value[wbyte[6:5]] <= wbyte[2:0];
        end
    end

    // OTG interrupt enable register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            otg_enable <= RST_ZERO;
        end else if (wr_en && paddr == ADDR_OTG_ENABLE) begin
            otg_enable <= wbyte & MASK_OTG_SIX;
        end
    end

    // OTG flags, write zero to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            otg_flags <= RST_ZERO;
        end else if (wr_en && paddr == ADDR_OTG_FLAGS) begin
            otg_flags <= ((otg_flags & wbyte) | otg_set) & MASK_OTG_SIX;
        end else begin
            otg_flags <= (otg_flags | otg_set) & MASK_OTG_SIX;
        end
    end

    // Read mux; reserved bits zero, timer top bit one
    always_comb begin
        next_rdata = 8'h00;
        mapped = 1'b1;
        case (paddr)
            ADDR_HW_CONFIG: next_rdata = hw_config;
            ADDR_GEN_CONTROL: next_rdata = gen_control;
            // speed in host role; id and bus power
            ADDR_GEN_STATUS: next_rdata = {4'h0, full_speed && host_role,
                1'b0, id_s, bus_power};
            ADDR_GEN_FLAGS: next_rdata = gen_flags;
            ADDR_DPRAM_HIGH: next_rdata = {ram_direct_access, 4'h0,
                ram_direct_addr[10:8]};
            ADDR_DPRAM_LOW: next_rdata = ram_direct_addr[7:0];
            ADDR_OTG_CONTROL: next_rdata = otg_control;
            ADDR_OTG_TIMER: next_rdata = TIMER_TOP_ONE
                | {1'b0, timer_page, 2'b00, timer_value[timer_page]};
            ADDR_OTG_ENABLE: next_rdata = otg_enable;
            ADDR_OTG_FLAGS: next_rdata = otg_flags;
            default: mapped = 1'b0;
        endcase
    end

    // Read data is captured in setup so it comes from a flop
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            prdata <= {24'h0, next_rdata};
        end
    end

    // Unmapped addresses answer with an error, writes are dropped
    assign pslverr = psel && penable && !mapped;

    // switch pin gated by its enable, regulator direct
    assign power_switch_pin = hw_config[PSW_EN_BIT] && power_request;
    assign pad_regulator_en = hw_config[REG_EN_BIT];
    // pad enable independent of controller enable
    assign otg_pad_enable = gen_control[PAD_EN_BIT];
    assign ctrl_reset = !controller_enable;
    assign transceiver_en = controller_enable;
    // freeze or disable stops clocks; resume detect stays on under freeze only
    assign ctrl_clk_en = controller_enable && !clock_freeze;
    assign resume_detect_en = controller_enable;
    assign host_select = gen_control[HOST_SEL_BIT];
    // one bit starts or accepts negotiation by role
    assign negotiation_request = otg_control[NEG_REQ_BIT] && controller_enable;
    assign session_method_select = otg_control[SES_SEL_BIT];
    assign vrise_timeout_sel = timer_value[0];
    assign bus_pulse_sel = timer_value[1];
    assign pulldown_timeout_sel = timer_value[2];
    assign session_detect_sel = timer_value[3];

    // any enabled flag raises the request
    assign usb_gen_irq = |(gen_flags & gen_control & MASK_GEN_FLAGS)
        || |(otg_flags & otg_enable);

    AST_HOST_SET: assert property (@(posedge ref_clk) disable iff (reset)
        (host_role && otg_pad_enable && hi_s) |=> bus_power)
        else $error("host flag not set at high threshold");
    AST_HOST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        (host_role && otg_pad_enable && sv_s && !hi_s && bus_power) |=> bus_power)
        else $error("host flag lost inside hysteresis");
    AST_DEV_FOLLOW: assert property (@(posedge ref_clk) disable iff (reset)
        (!host_role && otg_pad_enable) |=> (bus_power == $past(sv_s)))
        else $error("peripheral flag not following session");
    AST_POWER_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(bus_power) |=> gen_flags[0])
        else $error("bus power change not flagged");
    AST_ID_EDGE: assert property (@(posedge ref_clk) disable iff (reset)
        (id_s != id_prev) |=> gen_flags[1])
        else $error("id change not flagged");
    AST_PIN_ROLE: assert property (@(posedge ref_clk) disable iff (reset)
        (hw_config[ROLE_PIN_BIT] && id_s) |-> !host_role)
        else $error("id high without peripheral role");
    AST_SES_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
        (session_request_start && !wr_en) |=> !session_request ##1 !session_request_start)
        else $error("session request not self clearing");
    AST_PWR_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_en && paddr == ADDR_OTG_CONTROL && wbyte[PWR_CLR_BIT])
        |=> (!power_switch_pin && !otg_control[PWR_CLR_BIT]))
        else $error("power clear did not drop the pin");
    AST_STO: assert property (@(posedge ref_clk) disable iff (reset)
        sto_evt |=> otg_flags[STO_BIT] ##1 !sto_evt)
        else $error("suspend timeout not flagged once");
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (reset)
        (clock_freeze && !otg_flags[2] && !wr_en) |=> !otg_flags[2])
        else $error("OTG event raised while frozen");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
        (|(otg_flags & otg_enable)) |-> usb_gen_irq)
        else $error("enabled flag without interrupt");
endmodule
`default_nettype wire

// >>> verilog/uog_pkg.sv
// Shared constants of the USB general and on-the-go control block.
// Assumes an APB slave with 32-bit data; registers sit in the low byte.
`default_nettype none
package uog_pkg;
    // Register byte addresses, one aligned word each
    localparam logic [11:0] ADDR_HW_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_GEN_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_GEN_STATUS = 12'h008;
    localparam logic [11:0] ADDR_GEN_FLAGS = 12'h00c;
    localparam logic [11:0] ADDR_DPRAM_HIGH = 12'h010;
    localparam logic [11:0] ADDR_DPRAM_LOW = 12'h014;
    localparam logic [11:0] ADDR_OTG_CONTROL = 12'h018;
    localparam logic [11:0] ADDR_OTG_TIMER = 12'h01c;
    localparam logic [11:0] ADDR_OTG_ENABLE = 12'h020;
    localparam logic [11:0] ADDR_OTG_FLAGS = 12'h024;
    // Field positions
    localparam int ROLE_REG_BIT = 7;
    localparam int ROLE_PIN_BIT = 6;
    localparam int PSW_EN_BIT = 4;
    localparam int REG_EN_BIT = 0;
    localparam int CTRL_EN_BIT = 7;
    localparam int HOST_SEL_BIT = 6;
    localparam int FREEZE_BIT = 5;
    localparam int PAD_EN_BIT = 4;
    localparam int DIRECT_BIT = 7;
    localparam int NEG_REQ_BIT = 5;
    localparam int SES_REQ_BIT = 4;
    localparam int SES_SEL_BIT = 3;
    localparam int HW_DIS_BIT = 2;
    localparam int PWR_REQ_BIT = 1;
    localparam int PWR_CLR_BIT = 0;
    localparam int SPEED_BIT = 3;
    localparam int STO_BIT = 5;
    // Writable masks; bits outside read as zero
    localparam logic [7:0] MASK_HW_CONFIG = 8'hd1;
    localparam logic [7:0] MASK_GEN_CONTROL = 8'hf3;
    localparam logic [7:0] MASK_GEN_FLAGS = 8'h03;
    localparam logic [7:0] MASK_DPRAM_HIGH = 8'h87;
    localparam logic [7:0] MASK_OTG_CONTROL = 8'h3e;
    localparam logic [7:0] MASK_OTG_SIX = 8'h3f;
    localparam logic [7:0] TIMER_TOP_ONE = 8'h80;
    // Reset values
    localparam logic [7:0] RST_GEN_CONTROL = 8'h20;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Timing
    localparam longint CLK_HZ = 100_000_000;
    localparam longint SUSPEND_TIMEOUT_MS = 150;
    localparam int unsigned SUSPEND_TIMEOUT_CYCLES = 32'(SUSPEND_TIMEOUT_MS * CLK_HZ / 1000);
endpackage
`default_nettype wire

// >>> verilog/dummy_unused_placeholder_removed.sv
// Intentionally empty: no further design content.
`default_nettype none
`default_nettype wire

// >>> testbench/uog_cable_model.sv
// Cable side model: bus voltage in tenths of a volt and the plug type.
// Assumes the bench changes volt_dv and a_plug just after a clock edge.
`default_nettype none
module uog_cable_model (
    // Bench commands
    input wire logic [7:0] volt_dv,
    input wire logic a_plug,
    // Pad comparators and id pin
    output logic session_valid,
    output logic high_threshold_valid,
    output logic id_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign session_valid = (volt_dv >= 8'h0e);
    assign high_threshold_valid = (volt_dv >= 8'h2c);
    // A plug grounds id, else pulled up
    assign id_pin = !a_plug;
endmodule
`default_nettype wire

// >>> testbench/usb_otg_general_control_tb_top.sv
// Self-checking bench for the general and OTG control block.
// Assumes zero-wait APB, 2-flop pad sync and a short suspend count.
`default_nettype none
module usb_otg_general_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uog_pkg::*;
    localparam int unsigned TO_CYC = 20; // Short suspend count keeps the run brief
    logic ref_clk, reset, psel, penable, pwrite, susp, eda, a_plug, fs;
    // {neg req, method, ctrl reset, xcvr, resume, pad, regulator, host sel}
    wire [7:0] outs;
    logic pready, pslverr, id_pin, sv, htv, psw_pin, host_role, irq, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [10:0] ram_addr;
    logic [7:0] volt, r;
    logic [4:0] evt;
    logic [2:0] sel [4];
    logic [2:0] v [4];
    logic [32:0] exp_q [$]; // Expected {pslverr, prdata} of each read
    int bad_count = 0;
    int n_tests = 0;
    uog_cable_model i_cable (.volt_dv(volt), .a_plug(a_plug), .session_valid(sv),
        .high_threshold_valid(htv), .id_pin(id_pin));
    uog_top #(.SUSPEND_TIMEOUT_CYCLES(TO_CYC)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .id_pin(id_pin), .session_valid(sv), .high_threshold_valid(htv),
        .power_switch_pin(psw_pin), .pad_regulator_en(outs[1]), .otg_pad_enable(outs[2]),
        .ctrl_reset(outs[5]), .ctrl_clk_en(clk_en), .transceiver_en(outs[4]),
        .resume_detect_en(outs[3]), .host_role(host_role), .host_select(outs[0]),
        .full_speed(fs), .suspend_active(susp),
        .negotiation_error_evt(evt[4]), .role_swap_evt(evt[3]), .bconn_error_evt(evt[2]),
        .power_drop_evt(evt[1]), .session_detect_evt(evt[0]), .negotiation_request(outs[7]),
        .session_request_start(), .session_method_select(outs[6]), .endpoint_data_access(eda),
        .ram_direct_access(), .ram_direct_addr(ram_addr), .vrise_timeout_sel(sel[0]),
        .bus_pulse_sel(sel[1]), .pulldown_timeout_sel(sel[2]), .session_detect_sel(sel[3]),
        .usb_gen_irq(irq)
    );
    // Free-running 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Counts and reports one comparison
    task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // Closing report, also reached by an expired wait
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!w) exp_q.push_back(e);
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic err = 1'b0);
        apb(1'b0, a, 8'h00, {err, 24'h0, d});
    endtask
    // Waits n edges, then lets that edge's updates land
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Scoreboard: each finished read takes the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) check("read queue", 33'h0, 33'h1);
            else check("read", exp_q.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        void'($urandom(15688));
        {reset, psel, penable, pwrite, susp, eda, a_plug, fs} = 8'h80;
        {paddr, pwdata, volt, evt} = '0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values: control 0x20, status shows id high, timer top bit one
        for (int k = 0; k < 10; k++) begin
            rd(12'(4 * k), k == 1 ? 8'h20 : k == 2 ? 8'h02 : k == 7 ? 8'h80 : 8'h00);
        end
        rd(12'h028, 8'h00, 1'b1);
        check("ctrl outs", 8'h20, outs);
        wr(ADDR_HW_CONFIG, 8'hff);
        rd(ADDR_HW_CONFIG, 8'hd1);
        check("host role", 1'b0, host_role);
        check("ctrl outs", 8'h22, outs);
        wr(ADDR_DPRAM_HIGH, 8'hff);
        rd(ADDR_DPRAM_HIGH, 8'h87);
        r = 8'($urandom_range(0, 254));
        wr(ADDR_DPRAM_LOW, r);
        @(posedge ref_clk);
        eda <= 1'b1;
        @(posedge ref_clk);
        eda <= 1'b0;
        settle(1);
        check("ram addr", {3'h7, r + 8'h01}, ram_addr);
        // Each timer page keeps its own value
        for (int p = 0; p < 4; p++) begin
            v[p] = 3'($urandom);
            wr(ADDR_OTG_TIMER, {1'b1, 2'(p), 2'b11, v[p]});
            rd(ADDR_OTG_TIMER, {1'b1, 2'(p), 2'b00, v[p]});
        end
        for (int p = 0; p < 4; p++) check("timer sel", v[p], sel[p]);
        wr(ADDR_OTG_CONTROL, 8'h02);
        settle(0);
        check("power pin", 1'b1, psw_pin);
        wr(ADDR_OTG_CONTROL, 8'h01);
        settle(0);
        check("power pin", 1'b0, psw_pin);
        rd(ADDR_OTG_CONTROL, 8'h00);
        // Peripheral role: bus power follows session valid
        wr(ADDR_HW_CONFIG, 8'h80);
        wr(ADDR_GEN_CONTROL, 8'h33);
        settle(0);
        check("host role", 1'b0, host_role);
        @(posedge ref_clk);
        volt <= 8'($urandom_range(14, 43));
        settle(6);
        check("irq", 1'b1, irq);
        rd(ADDR_GEN_STATUS, 8'h03);
        rd(ADDR_GEN_FLAGS, 8'h01);
        wr(ADDR_GEN_FLAGS, 8'h00);
        settle(0);
        check("irq", 1'b0, irq);
        @(posedge ref_clk);
        volt <= 8'h00;
        settle(6);
        rd(ADDR_GEN_FLAGS, 8'h01);
        wr(ADDR_GEN_FLAGS, 8'h00);
        // Host role: set at high threshold, clear below session valid
        wr(ADDR_HW_CONFIG, 8'h00);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            volt <= k == 1 ? 8'h32 : k == 3 ? 8'h00 : 8'($urandom_range(14, 43));
            fs <= k[0];
            settle(6);
            rd(ADDR_GEN_STATUS, {4'h0, k[0], 2'b01, k == 1 || k == 2});
        end
        rd(ADDR_GEN_FLAGS, 8'h01);
        wr(ADDR_GEN_FLAGS, 8'h00);
        // A plug through the pin source
        wr(ADDR_HW_CONFIG, 8'h40);
        a_plug <= 1'b1;
        settle(6);
        check("host role", 1'b1, host_role);
        rd(ADDR_GEN_STATUS, 8'h08);
        rd(ADDR_GEN_FLAGS, 8'h02);
        // OTG events, frozen first, then running
        wr(ADDR_OTG_ENABLE, 8'h3f);
        for (int f = 1; f >= 0; f--) begin
            wr(ADDR_GEN_CONTROL, f ? 8'hf3 : 8'h93);
            settle(0);
            check("clock enable", !f, clk_en);
            check("ctrl outs", f ? 8'h1d : 8'h1c, outs);
            for (int k = 0; k < 5; k++) begin
                @(posedge ref_clk);
                evt <= 5'(1 << k);
                @(posedge ref_clk);
                evt <= 5'h00;
                rd(ADDR_OTG_FLAGS, f ? 8'h00 : 8'(1 << k));
                wr(ADDR_OTG_FLAGS, 8'h00);
            end
        end
        // Suspend timeout after the full count only
        wr(ADDR_GEN_FLAGS, 8'h00);
        wr(ADDR_OTG_ENABLE, 8'h20);
        @(posedge ref_clk);
        susp <= 1'b1;
        settle(TO_CYC - 4);
        check("irq", 1'b0, irq);
        settle(8);
        check("irq", 1'b1, irq);
        rd(ADDR_OTG_FLAGS, 8'h20);
        // Requests: a power request survives a drop with hardware control disabled, then clears on a drop once enabled
        wr(ADDR_OTG_CONTROL, 8'h2e);
        settle(0);
        check("ctrl outs", 8'hdc, outs);
        @(posedge ref_clk);
        evt <= 5'h02;
        a_plug <= 1'b0;
        @(posedge ref_clk);
        evt <= 5'h00;
        settle(6);
        rd(ADDR_OTG_CONTROL, 8'h2e);
        wr(ADDR_OTG_CONTROL, 8'h02);
        @(posedge ref_clk);
        evt <= 5'h02;
        @(posedge ref_clk);
        evt <= 5'h00;
        rd(ADDR_OTG_CONTROL, 8'h00);
        // Let the last read reach the scoreboard before the verdict
        settle(1);
        print_verdict();
    end
endmodule
`default_nettype wire
